/* File: hw/mbmr_pkg.sv */
package mbmr_pkg;
	// Frame characters
	localparam logic [7:0] CHAR_START = 8'h3A;     // Frame start
	localparam logic [7:0] CHAR_CR    = 8'h0D;     // First terminator
	localparam logic [7:0] CHAR_LF    = 8'h0A;     // Second terminator
	localparam logic [7:0] FUNC_READ  = 8'h03;     // Read holding registers
	// Monitor register map
	localparam logic [15:0] REG_INP_STATE = 16'h2522; // digital_input_terminal_state
	localparam logic [15:0] REG_FREQ_CMD  = 16'h2523; // commanded_frequency
	localparam logic [15:0] REG_OUT_FREQ  = 16'h2524; // actual_output_frequency
	localparam logic [15:0] REG_DC_CMD    = 16'h2526; // dc_bus_voltage_command
	localparam logic [15:0] REG_CURRENT   = 16'h2527; // motor_output_current
	localparam logic [15:0] REG_WARNING   = 16'h2528; // active_warning_code
	localparam logic [15:0] REG_DO_STATE  = 16'h2529; // digital_output_state
	localparam logic [15:0] REG_AIN_ONE   = 16'h252C; // analog_input_one_value
	localparam logic [15:0] REG_AIN_TWO   = 16'h252D; // analog_input_two_value
	localparam logic [15:0] REG_CHECK     = 16'h252F; // model_check_word
	// Field layout of a request, in binary bytes after the start character
	localparam logic [3:0] BYTES_IN_REQ  = 4'h6;   // Addr, func, start(2), count(2)
	localparam logic [3:0] POS_LRC       = 4'h6;   // Index of LRC byte
	localparam int         INP_USED_BITS = 8;      // Terminals one to eight

	// Parser states
	typedef enum logic [2:0] {
		MBMR_IDLE  = 3'b000,
		MBMR_HIGH  = 3'b001,
		MBMR_LOW   = 3'b010,
		MBMR_LF    = 3'b011,
		MBMR_READ  = 3'b100
	} mbmr_state_type;

	// Decoded request
	typedef struct packed {
		logic [7:0]  node;   // Node address
		logic [7:0]  func;   // Function code
		logic [15:0] start;  // Starting register
		logic [15:0] count;  // Register count
	} mbmr_req_type;

	// Monitor inputs gathered
	typedef struct packed {
		logic [7:0]  digital_input;  // Terminals one..eight
		logic [15:0] freq_cmd;       // Commanded frequency
		logic [15:0] out_freq;       // Output frequency
		logic [15:0] dc_cmd;         // DC bus voltage command
		logic [15:0] current;        // Output current
		logic [15:0] warning;        // Warning code
		logic [15:0] do_state;       // Digital output state
		logic [15:0] ain_one;        // Analog input 1
		logic [15:0] ain_two;        // Analog input 2
	} mbmr_mon_type;
endpackage : mbmr_pkg

/* File: hw/mbmr_hex_nibble.sv */
`timescale 1ns/1ns
// Converts one ASCII hex character to a nibble
module mbmr_hex_nibble (
	input  wire logic [7:0] i_char,   // ASCII character
	output logic      [3:0] o_nib,    // Nibble value
	output logic            o_valid   // Character is hex
);
	// Decode 0-9, A-F, a-f
	always_comb
	begin
		o_nib   = 4'h0;
		o_valid = 1'b1;
		if (i_char >= 8'h30 && i_char <= 8'h39)
		begin
			o_nib = i_char[3:0];
		end
		else if ((i_char >= 8'h41 && i_char <= 8'h46) || (i_char >= 8'h61 && i_char <= 8'h66))
		begin
			o_nib = 4'(i_char[3:0] + 4'h9);
		end
		else
		begin
			o_valid = 1'b0;
		end
	end
endmodule : mbmr_hex_nibble

/* File: hw/mbmr_read_slave.sv */
`timescale 1ns/1ns
// Functional notes
// - Function 03H reads consecutive holding registers
// - Registers returned upward from starting register
// - Start 3AH, then address, function, start, count
// - Frame complete only after 0DH then 0AH
module mbmr_read_slave #(
	parameter logic [7:0]  NODE_ADDR  = 8'h01,   // Own node address
	parameter logic [15:0] CHECK_WORD = 16'h0000 // Model check word, arbitrary value
) (
	input  wire logic                  i_clock,     // 20 MHz system clock
	input  wire logic                  i_rst_n,     // Async reset, active low
	input  wire logic [7:0]            i_rx_data,   // Received character
	input  wire logic                  i_rx_valid,  // Character strobe
	input  wire mbmr_pkg::mbmr_mon_type i_monitor,  // Live monitor values
	input  wire logic                  i_rd_ready,  // Reply side takes word
	output logic                       o_rd_valid,  // Register word valid
	output logic [15:0]                o_rd_addr,   // Register address of word
	output logic [15:0]                o_rd_data,   // Register contents
	output logic                       o_rd_last,   // Last word of reply
	output logic                       o_frame_err, // Pulse: frame discarded
	output logic                       o_busy       // Reply in progress
);
	// Whole module state
	typedef struct packed {
		mbmr_pkg::mbmr_state_type st;     // Parser state
		logic [3:0]               idx;    // Binary byte index
		logic [3:0]               hi;     // Pending high nibble
		logic [7:0]               sum;    // Running byte sum
		logic                     bad;    // Bad character seen
		mbmr_pkg::mbmr_req_type   req;    // Captured request
		logic [15:0]              addr;   // Current register
		logic [15:0]              left;   // Words remaining
		logic                     rd_valid; // Word valid
		logic [15:0]              rd_addr;  // Word address
		logic [15:0]              rd_data;  // Word contents
		logic                     rd_last;  // Last word flag
		logic                     err;      // Discard pulse
		logic                     busy;     // Reply in progress
	} mbmr_regs_type;

	mbmr_regs_type s_q;  // Registered state
	mbmr_regs_type s_d;  // Next state
	logic [3:0]    nib;  // Decoded nibble
	logic          nib_ok; // Character is hex
	logic [7:0]    byte_val; // Assembled byte

	// Hex character decoder
	mbmr_hex_nibble u_nib (
		.i_char  (i_rx_data),
		.o_nib   (nib),
		.o_valid (nib_ok)
	);

	assign byte_val = {s_q.hi, nib};

	// Map lookup of one register
	function automatic logic [15:0] mbmr_lookup(input logic [15:0] a, input mbmr_pkg::mbmr_mon_type m);
		logic [15:0] v;
		v = 16'h0000;
		unique case (a)
			mbmr_pkg::REG_INP_STATE: v = {8'h00, m.digital_input[mbmr_pkg::INP_USED_BITS-1:0]};
			mbmr_pkg::REG_FREQ_CMD: v = m.freq_cmd;
			mbmr_pkg::REG_OUT_FREQ: v = m.out_freq;
			mbmr_pkg::REG_DC_CMD:   v = m.dc_cmd;
			mbmr_pkg::REG_CURRENT:  v = m.current;
			mbmr_pkg::REG_WARNING:  v = m.warning;
			mbmr_pkg::REG_DO_STATE: v = m.do_state;
			mbmr_pkg::REG_AIN_ONE:  v = m.ain_one;
			mbmr_pkg::REG_AIN_TWO:  v = m.ain_two;
			mbmr_pkg::REG_CHECK:    v = CHECK_WORD;
			default:                v = 16'h0000; // Reserved reads zero
		endcase
		return v;
	endfunction : mbmr_lookup

	// Next-state logic
	always_comb
	begin
		s_d     = s_q;
		s_d.err = 1'b0;
		// A new start character restarts the parser, except while a reply is streaming (MBMR_READ)
		if (i_rx_valid && i_rx_data == mbmr_pkg::CHAR_START && s_q.st != mbmr_pkg::MBMR_READ)
		begin
			s_d.st  = mbmr_pkg::MBMR_HIGH;
			s_d.idx = 4'h0;
			s_d.sum = 8'h00;
			s_d.bad = 1'b0;
		end
		else
		begin
			unique case (s_q.st)
				mbmr_pkg::MBMR_IDLE:
				begin
					s_d.st = mbmr_pkg::MBMR_IDLE; // Wait for start
				end
				mbmr_pkg::MBMR_HIGH:
				begin
					if (i_rx_valid)
					begin
						if (i_rx_data == mbmr_pkg::CHAR_CR)
						begin
							// CR only legal after the LRC byte
							if (s_q.idx == 4'(mbmr_pkg::POS_LRC + 4'h1))
							begin
								s_d.st = mbmr_pkg::MBMR_LF;
							end
							else
							begin
								s_d.st  = mbmr_pkg::MBMR_IDLE;
								s_d.err = 1'b1;
							end
						end
						else
						begin
							s_d.hi  = nib;
							s_d.bad = s_q.bad | ~nib_ok;
							s_d.st  = mbmr_pkg::MBMR_LOW;
						end
					end
				end
				mbmr_pkg::MBMR_LOW:
				begin
					if (i_rx_valid)
					begin
						s_d.bad = s_q.bad | ~nib_ok;
						s_d.sum = 8'(s_q.sum + byte_val);
						s_d.idx = 4'(s_q.idx + 4'h1);
						s_d.st  = mbmr_pkg::MBMR_HIGH;
						// Place binary bytes into request fields
						unique case (s_q.idx)
							4'h0: s_d.req.node        = byte_val;
							4'h1: s_d.req.func        = byte_val;
							4'h2: s_d.req.start[15:8] = byte_val;
							4'h3: s_d.req.start[7:0]  = byte_val;
							4'h4: s_d.req.count[15:8] = byte_val;
							4'h5: s_d.req.count[7:0]  = byte_val;
							default: s_d.st = (s_q.idx > mbmr_pkg::POS_LRC) ? mbmr_pkg::MBMR_IDLE
							                                                 : mbmr_pkg::MBMR_HIGH;
						endcase
						if (s_q.idx > mbmr_pkg::POS_LRC)
						begin
							s_d.err = 1'b1; // Too many characters
						end
					end
				end
				mbmr_pkg::MBMR_LF:
				begin
					if (i_rx_valid)
					begin
						s_d.st = mbmr_pkg::MBMR_IDLE;
						// Accept only with LF, clean hex, zero sum, own node, read, nonzero count
						if (i_rx_data == mbmr_pkg::CHAR_LF && !s_q.bad && s_q.sum == 8'h00)
						begin
							if (s_q.req.node == NODE_ADDR && s_q.req.func == mbmr_pkg::FUNC_READ
							    && s_q.req.count != 16'h0000)
							begin
								s_d.st   = mbmr_pkg::MBMR_READ;
								s_d.addr = s_q.req.start;
								s_d.left = s_q.req.count;
							end
						end
						else
						begin
							s_d.err = 1'b1;
						end
					end
				end
				mbmr_pkg::MBMR_READ:
				begin
					// Stream words upward, one per accepted handshake
					if (!s_q.rd_valid || i_rd_ready)
					begin
						if (s_q.left != 16'h0000)
						begin
							s_d.rd_valid = 1'b1;
							s_d.rd_addr  = s_q.addr;
							s_d.rd_data  = mbmr_lookup(s_q.addr, i_monitor);
							s_d.rd_last  = (s_q.left == 16'h0001);
							s_d.addr     = 16'(s_q.addr + 16'h0001);
							s_d.left     = 16'(s_q.left - 16'h0001);
						end
						else
						begin
							s_d.rd_valid = 1'b0;
							s_d.rd_last  = 1'b0;
							s_d.st       = mbmr_pkg::MBMR_IDLE;
						end
					end
				end
				default:
				begin
					s_d.st = mbmr_pkg::MBMR_IDLE; // Illegal code recovers
				end
			endcase
		end
		// Busy kept in a flop so the output needs no decode
		s_d.busy = (s_d.st == mbmr_pkg::MBMR_READ);
	end

	// State register
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flip-flops
	assign o_rd_valid  = s_q.rd_valid;
	assign o_rd_addr   = s_q.rd_addr;
	assign o_rd_data   = s_q.rd_data;
	assign o_rd_last   = s_q.rd_last;
	assign o_frame_err = s_q.err;
	assign o_busy      = s_q.busy;
endmodule : mbmr_read_slave

/* File: bench/mbmr_read_slave_asserts.sv */
`timescale 1ns/1ns
// Port checker for the reply stream
module mbmr_read_slave_asserts (
	input wire logic                   i_clock,     // Clock
	input wire logic                   i_rst_n,     // Reset
	input wire logic [7:0]             i_rx_data,   // Character
	input wire logic                   i_rx_valid,  // Strobe
	input wire mbmr_pkg::mbmr_mon_type i_monitor,   // Monitor
	input wire logic                   i_rd_ready,  // Taken
	input wire logic                   o_rd_valid,  // Valid
	input wire logic [15:0]            o_rd_addr,   // Address
	input wire logic [15:0]            o_rd_data,   // Data
	input wire logic                   o_rd_last,   // Last
	input wire logic                   o_frame_err, // Discard
	input wire logic                   o_busy       // Busy
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	chk_word_holds: assert property (o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable({o_rd_addr, o_rd_data}))
		else $error("word changed before taken");
	chk_addr_steps: assert property (
		o_rd_valid && i_rd_ready && !o_rd_last |=> o_rd_addr == $past(o_rd_addr) + 16'h0001)
		else $error("address did not step by one");
	chk_last_ends: assert property (o_rd_valid && i_rd_ready && o_rd_last |=> !o_rd_valid ##[0:1] !o_busy)
		else $error("reply ran past last word");
	chk_valid_busy: assert property (o_rd_valid |-> o_busy)
		else $error("word outside reply");
	chk_busy_on_lf: assert property ($rose(o_busy) |-> $past(i_rx_valid) && $past(i_rx_data) == mbmr_pkg::CHAR_LF)
		else $error("reply began without terminator");
	chk_first_word: assert property ($rose(o_busy) |=> o_rd_valid)
		else $error("first word late");
	chk_err_pulse: assert property (o_frame_err |=> !o_frame_err)
		else $error("discard pulse too long");
	chk_input_word: assert property (
		o_rd_valid && o_rd_addr == mbmr_pkg::REG_INP_STATE |-> o_rd_data == {8'h00, i_monitor.digital_input})
		else $error("input state word wrong");
endmodule : mbmr_read_slave_asserts

/* File: bench/mbmr_master_model.sv */
`timescale 1ns/1ns
// Master side: ASCII read requests, one character a clock
module mbmr_master_model (
	input  wire logic       i_clock,    // Clock
	output logic      [7:0] o_rx_data,  // Character
	output logic            o_rx_valid  // Strobe
);
	initial o_rx_data = 8'h00;
	initial o_rx_valid = 1'b0;
	// Nibble to upper-case hex character
	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
	endfunction : hx
	// One character on the next edge
	task automatic put(input logic [7:0] c);
		@(posedge i_clock);
		o_rx_data <= c;
		o_rx_valid <= 1'b1;
	endtask : put
	// Builds a frame from any function code in r, write codes included
	task automatic send(input mbmr_pkg::mbmr_req_type r, input logic [7:0] flip);
		logic [7:0] b;
		logic [7:0] s;
		s = 8'h00;
		put(mbmr_pkg::CHAR_START);
		for (int i = 5; i >= 0; i--)
		begin
			b = r[i*8 +: 8];
			s = s + b;
			put(hx(b[7:4]));
			put(hx(b[3:0]));
		end
		b = (8'h00 - s) ^ flip;
		put(hx(b[7:4]));
		put(hx(b[3:0]));
		put(mbmr_pkg::CHAR_CR);
		put(mbmr_pkg::CHAR_LF);
		@(posedge i_clock);
		o_rx_valid <= 1'b0;
		o_rx_data <= ~o_rx_data;
	endtask : send
endmodule : mbmr_master_model

/* File: bench/mbmr_read_slave_bench.sv */
`timescale 1ns/1ns
// Read requests through the master model, word stream checked
module mbmr_read_slave_bench;
	logic                   i_clock = 1'b0;    // Clock
	logic                   i_rst_n = 1'b0;    // Reset
	logic [7:0]             rx_data;           // Character
	logic                   rx_valid;          // Strobe
	logic                   i_rd_ready = 1'b0; // Taken
	logic                   rd_valid, rd_last, frame_err, busy; // Outputs
	logic [15:0]            rd_addr, rd_data;  // Word
	int                     failures = 0;      // Mismatches
	int                     check_count = 0;   // Comparisons
	int                     err_seen = 0;      // Discard pulses
	int                     w;                 // Wait count
	mbmr_pkg::mbmr_mon_type i_monitor = {8'hA5, 16'h1023, 16'h1024, 16'h1026, 16'h1027,
		16'h1028, 16'h1029, 16'h102C, 16'h102D}; // Monitor
	mbmr_pkg::mbmr_req_type bad [4] = '{48'h0103_2522_0001, 48'h0203_2522_0001, 48'h0106_2522_0001,
		48'h0103_2522_0000}; // Rejects: bad check, other node, other function, zero count
	mbmr_master_model i_master (.i_clock(i_clock), .o_rx_data(rx_data), .o_rx_valid(rx_valid));
	mbmr_read_slave #(.CHECK_WORD(16'h5A5A)) i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_rx_data(rx_data),
		.i_rx_valid(rx_valid), .i_monitor(i_monitor), .i_rd_ready(i_rd_ready), .o_rd_valid(rd_valid),
		.o_rd_addr(rd_addr), .o_rd_data(rd_data), .o_rd_last(rd_last), .o_frame_err(frame_err), .o_busy(busy));
	always #25 i_clock = ~i_clock;
	// Discard pulse counter
	always @(posedge i_clock) if (frame_err === 1'b1) err_seen++;
	// Expected word per address
	function automatic logic [15:0] expv(input logic [15:0] a);
		if (a == mbmr_pkg::REG_INP_STATE)
			return 16'h00A5;
		if (a inside {16'h2523, 16'h2524, [16'h2526:16'h2529], 16'h252C, 16'h252D})
			return {8'h10, a[7:0]};
		return (a == mbmr_pkg::REG_CHECK) ? 16'h5A5A : 16'h0000;
	endfunction : expv
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			failures++;
		end
	endtask : check
	// Takes n words, stalling one cycle each
	task automatic take(input logic [15:0] a, input int n);
		for (int k = 0; k < n; k++)
		begin
			w = 0;
			while (rd_valid !== 1'b1 && w < 40)
			begin
				@(posedge i_clock);
				#1 w++;
			end
			check({14'h0, busy, rd_valid}, 16'h0003);
			check(rd_addr, a + k[15:0]);
			check(rd_data, expv(a + k[15:0]));
			check({15'h0, rd_last}, {15'h0, k == n - 1});
			@(posedge i_clock) i_rd_ready <= 1'b1;
			@(posedge i_clock) i_rd_ready <= 1'b0;
			#1;
		end
		check({14'h0, busy, rd_valid}, 16'h0000);
	endtask : take
	task automatic end_of_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	// Watchdog
	initial
	begin
		#1000000;
		failures++;
		end_of_test();
	end
	// Main sequence
	initial
	begin
		repeat (10) @(posedge i_clock);
		i_rst_n <= 1'b1;
		i_master.send(48'h0103_2522_000E, 8'h00);
		take(16'h2522, 14);
		for (int j = 0; j < 4; j++)
		begin
			i_master.send(bad[j], (j == 0) ? 8'h01 : 8'h00);
			repeat (6) @(posedge i_clock);
			check({15'h0, busy}, 16'h0000);
			check(err_seen[15:0], 16'h0001);
		end
		i_master.send(48'h0103_252F_0001, 8'h00);
		take(16'h252F, 1);
		end_of_test();
	end
endmodule : mbmr_read_slave_bench
bind mbmr_read_slave mbmr_read_slave_asserts i_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_rx_data(i_rx_data),
	.i_rx_valid(i_rx_valid), .i_monitor(i_monitor), .i_rd_ready(i_rd_ready), .o_rd_valid(o_rd_valid),
	.o_rd_addr(o_rd_addr), .o_rd_data(o_rd_data), .o_rd_last(o_rd_last), .o_frame_err(o_frame_err), .o_busy(o_busy));
